/* acr_pkg.sv */
/*
 * Package for the converter control and result register block.
 * Holds register offsets, field positions, reset values and clock codes.
 * Assumes a single 125 MHz system clock.
 */
`default_nettype none
package acr_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ADDR_CTRL0     = 3'h0;
    localparam logic [2:0] ADDR_CTRL1     = 3'h1;
    localparam logic [2:0] ADDR_RES_HIGH  = 3'h2;
    localparam logic [2:0] ADDR_RES_LOW   = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STAT  = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK  = 3'h5;
    // First control register fields
    localparam int         BIT_JUSTIFY    = 7;
    localparam int         BIT_REFSEL     = 6;
    localparam int         BIT_CHAN_HI    = 4;
    localparam int         BIT_CHAN_LO    = 2;
    localparam int         BIT_START      = 1;
    localparam int         BIT_ENABLE     = 0;
    // Second control register field
    localparam int         BIT_CLK_HI     = 6;
    localparam int         BIT_CLK_LO     = 4;
    // Reset values
    localparam logic [7:0] CTRL0_RESET    = 8'h00;
    localparam logic [2:0] CLKSEL_RESET   = 3'h0;
    // Conversion timing in conversion clock periods
    localparam logic [3:0] CONV_PERIODS   = 4'hb;
    localparam logic [3:0] ABORT_PERIODS  = 4'h2;
    // Internal RC clock: 500 kHz period in ns, cycles of the 125 MHz clock
    localparam int         SYS_PERIOD_NS  = 8;
    localparam int         RC_PERIOD_NS   = 2000;
    localparam int         RC_DIV         = RC_PERIOD_NS / SYS_PERIOD_NS;
    // Conversion clock codes
    localparam logic [2:0] CLK_DIV2       = 3'h0;
    localparam logic [2:0] CLK_DIV4       = 3'h4;
    localparam logic [2:0] CLK_DIV8       = 3'h1;
    localparam logic [2:0] CLK_DIV16      = 3'h5;
    localparam logic [2:0] CLK_DIV32      = 3'h2;
    localparam logic [2:0] CLK_DIV64      = 3'h6;
    // Interrupt status bit of conversion done
    localparam int         IRQ_DONE_BIT   = 0;
    // Conversion states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONV  = 3'b010,
        ST_ABORT = 3'b100
    } acr_state_t;
endpackage : acr_pkg
`default_nettype wire

/* acr_top.sv */
/*
 * Control and result registers of a 10-bit successive approximation
 * converter: control bits, clock divider, conversion sequencer, result
 * justification and a done interrupt.
 * Assumes a register master on sys_clk and an analog front end that
 * returns sample bits serially, one per conversion clock period.
 * Result bytes have no reset and read undefined until first loaded.
 */
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// What this block and its software do
// RULE1: Justify bit 7: 1 right, 0 left
// RULE2: Reference bit 6: 1 external pin, 0 supply
// RULE3: Channel field bits 4-2 picks input n
// RULE4: Start bit set starts, hardware clears at end
// RULE5: Enable bit 0 powers converter
// RULE6: Clock field bits 6-4 selects divider or RC
// RULE7: Left format: high 9-2, low 1-0 top
// RULE8: Right format: high 9-8 low, low 7-0
// RULE9: Unimplemented control bits read as zero
// RULE10: Software waits acquisition time before start
// RULE11: Hold capacitor never discharged between conversions
// RULE12: Software ignores reserved result bits
// RULE13: Completion clears start, sets flag, loads result
// RULE14: Abort keeps result, two-period delay, reacquire
// RULE15: Conversion lasts eleven conversion clock periods
// RULE16: Done flag always set, software clears only
// RULE17: Result registers not cleared by reset
// RULE18: Start ignored while converter disabled
module acr_top (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // Analog front end
    input  wire logic       cmp_in,
    output logic            analog_on,
    output logic            ref_external,
    output logic      [2:0] channel,
    output logic            sample_hold,
    output logic            conv_tick,
    // Interrupt
    output logic            irq
);
    // Control state
    logic       justify_select;       // 1 right justified
    logic       reference_select;     // 1 external reference
    logic [2:0] channel_select;       // Input channel
    logic       converter_enable;     // Converter on
    logic       start_busy;           // Start and busy bit
    logic [2:0] conv_clock_select;    // Conversion clock code
    logic [7:0] result_high;          // Result high byte
    logic [7:0] result_low;           // Result low byte
    logic       conversion_done_flag; // Sticky done status
    logic       done_mask;            // Done interrupt enable
    acr_pkg::acr_state_t state;       // Sequencer state
    logic [3:0] period_cnt;           // Conversion periods counted
    logic [9:0] sar;                  // Bits collected so far
    logic [7:0] div_cnt;              // Prescaler counter
    logic       cmp_meta;             // Comparator sync first stage
    logic       cmp_sync;             // Comparator sync second stage

    // Register decode
    wire wr_ctrl0 = reg_write && reg_addr == acr_pkg::ADDR_CTRL0;
    wire wr_ctrl1 = reg_write && reg_addr == acr_pkg::ADDR_CTRL1;
    wire wr_high  = reg_write && reg_addr == acr_pkg::ADDR_RES_HIGH;
    wire wr_low   = reg_write && reg_addr == acr_pkg::ADDR_RES_LOW;
    wire wr_stat  = reg_write && reg_addr == acr_pkg::ADDR_IRQ_STAT;
    wire wr_mask  = reg_write && reg_addr == acr_pkg::ADDR_IRQ_MASK;
    wire wr_start = wr_ctrl0 && reg_wdata[acr_pkg::BIT_START];
    wire wr_en    = wr_ctrl0 && reg_wdata[acr_pkg::BIT_ENABLE];

    // Divider terminal count per clock code; codes x11 fall to the
    // default arm, the RC clock modelled as a fixed divider so the
    // sequencer sees one kind of tick
    logic [7:0] div_last;
    always_comb
    begin
        unique case (conv_clock_select)
            acr_pkg::CLK_DIV2:  div_last = 8'd1;                // [RULE6]
            acr_pkg::CLK_DIV4:  div_last = 8'd3;
            acr_pkg::CLK_DIV8:  div_last = 8'd7;
            acr_pkg::CLK_DIV16: div_last = 8'd15;
            acr_pkg::CLK_DIV32: div_last = 8'd31;
            acr_pkg::CLK_DIV64: div_last = 8'd63;
            default:            div_last = 8'(acr_pkg::RC_DIV - 1);
        endcase
    end
    wire tick = div_cnt >= div_last;

    // Sequencer events
    wire in_idle   = state == acr_pkg::ST_IDLE;
    wire in_conv   = state == acr_pkg::ST_CONV;
    wire in_abort  = state == acr_pkg::ST_ABORT;
    // Start is taken only from idle with the converter already on; a
    // start during the abort delay or with enable low is dropped
    wire go        = in_idle && wr_start && converter_enable;   // [RULE18]
    // Clearing start or enable in flight abandons the conversion
    wire sw_abort  = in_conv && wr_ctrl0 && !reg_wdata[acr_pkg::BIT_START];
    wire off_abort = in_conv && !converter_enable;
    wire last_tick = in_conv && tick
                     && period_cnt == acr_pkg::CONV_PERIODS - 4'd1;
    wire finish    = last_tick && !sw_abort && !off_abort;      // [RULE15]
    // Last bit comes straight from the synchroniser
    wire [9:0] final_value = {sar[8:0], cmp_sync};

    // Justified result bytes
    wire [7:0] next_high = justify_select
        ? {6'h00, final_value[9:8]}                             // [RULE8]
        : final_value[9:2];                                     // [RULE7]
    wire [7:0] next_low  = justify_select
        ? final_value[7:0]                                      // [RULE8]
        : {final_value[1:0], 6'h00};                            // [RULE7]

    // Comparator synchroniser
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end
        else
        begin
            // Only the second stage is read by logic
            cmp_meta <= cmp_in;
            cmp_sync <= cmp_meta;
        end
    end

    // Conversion clock prescaler, restarts at each start
    // Free running otherwise, so an abort delay may start mid-period
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            div_cnt <= 8'h00;
        else if (go || tick)
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'd1;
    end

    // Sequencer state
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            state <= acr_pkg::ST_IDLE;
        else
        begin
            unique case (state)
                acr_pkg::ST_IDLE:
                    if (go)
                        state <= acr_pkg::ST_CONV;              // [RULE4]
                // Abort wins over a finish in the same cycle
                acr_pkg::ST_CONV:
                    if (sw_abort || off_abort)
                        state <= acr_pkg::ST_ABORT;             // [RULE14]
                    else if (finish)
                        state <= acr_pkg::ST_IDLE;
                // New starts held off for two conversion periods
                acr_pkg::ST_ABORT:
                    if (tick && period_cnt == acr_pkg::ABORT_PERIODS - 4'd1)
                        state <= acr_pkg::ST_IDLE;              // [RULE14]
                default:
                    state <= acr_pkg::ST_IDLE;
            endcase
        end
    end

    // Period counter, shared by conversion and abort delay
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            period_cnt <= 4'h0;
        else if (go || sw_abort || off_abort)
            period_cnt <= 4'h0;
        // Counts only while converting or in the abort delay
        else if (tick && (in_conv || in_abort))
            period_cnt <= period_cnt + 4'd1;                    // [RULE15]
    end

    // Successive approximation bits, first period is sampling
    // Period zero is the acquisition, so nothing shifts there
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            sar <= 10'h000;
        else if (go)
            sar <= 10'h000;
        else if (in_conv && tick && period_cnt != 4'h0)
            sar <= {sar[8:0], cmp_sync};
    end

    // First control register
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            justify_select   <= acr_pkg::CTRL0_RESET[acr_pkg::BIT_JUSTIFY];
            reference_select <= acr_pkg::CTRL0_RESET[acr_pkg::BIT_REFSEL];
            channel_select   <= acr_pkg::CTRL0_RESET[acr_pkg::BIT_CHAN_HI:
                                                     acr_pkg::BIT_CHAN_LO];
            converter_enable <= acr_pkg::CTRL0_RESET[acr_pkg::BIT_ENABLE];
        end
        else if (wr_ctrl0)
        begin
            justify_select   <= reg_wdata[acr_pkg::BIT_JUSTIFY];  // [RULE1]
            reference_select <= reg_wdata[acr_pkg::BIT_REFSEL];   // [RULE2]
            channel_select   <= reg_wdata[acr_pkg::BIT_CHAN_HI:
                                          acr_pkg::BIT_CHAN_LO];  // [RULE3]
            converter_enable <= reg_wdata[acr_pkg::BIT_ENABLE];   // [RULE5]
        end
    end

    // Start and busy bit: set by accepted start, cleared at end or abort
    // A start while busy, aborting or disabled leaves it untouched
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            start_busy <= 1'b0;
        else if (go)
            start_busy <= 1'b1;                                 // [RULE4]
        else if (finish || sw_abort || off_abort)
            start_busy <= 1'b0;                                 // [RULE13]
    end

    // Second control register
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            conv_clock_select <= acr_pkg::CLKSEL_RESET;
        else if (wr_ctrl1)
            conv_clock_select <= reg_wdata[acr_pkg::BIT_CLK_HI:
                                           acr_pkg::BIT_CLK_LO]; // [RULE6]
    end

    // Result pair: no reset, loaded only on completion or software write
    // A software write in the completion cycle is dropped
    always_ff @(posedge sys_clk)                                // [RULE17]
    begin
        if (finish)
        begin
            result_high <= next_high;                           // [RULE13]
            result_low  <= next_low;
        end
        else
        begin
            if (wr_high)
                result_high <= reg_wdata;
            if (wr_low)
                result_low <= reg_wdata;
        end
    end

    // Done flag and mask; set wins over write-one-to-clear
    // The mask gates only the output, never the flag
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            conversion_done_flag <= 1'b0;
            done_mask            <= 1'b0;
        end
        else
        begin
            if (finish)
                conversion_done_flag <= 1'b1;                   // [RULE16]
            else if (wr_stat && reg_wdata[acr_pkg::IRQ_DONE_BIT])
                conversion_done_flag <= 1'b0;
            if (wr_mask)
                done_mask <= reg_wdata[acr_pkg::IRQ_DONE_BIT];
        end
    end

    // Read data selection
    // Unmapped indices and reserved positions read as zero
    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            acr_pkg::ADDR_CTRL0:
                next_rdata = {justify_select, reference_select, 1'b0,
                              channel_select, start_busy,
                              converter_enable};                // [RULE9]
            acr_pkg::ADDR_CTRL1:
                next_rdata = {1'b0, conv_clock_select, 4'h0};   // [RULE9]
            acr_pkg::ADDR_RES_HIGH: next_rdata = result_high;
            acr_pkg::ADDR_RES_LOW:  next_rdata = result_low;
            acr_pkg::ADDR_IRQ_STAT: next_rdata = {7'h00, conversion_done_flag};
            acr_pkg::ADDR_IRQ_MASK: next_rdata = {7'h00, done_mask};
            default:                next_rdata = 8'h00;
        endcase
    end

    // Registered read data, valid the cycle after the strobe
    // Zero outside the answer cycle keeps the port quiet
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (reg_read)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 8'h00;
    end

    // Registered front end controls and interrupt
    // Every pin-side output comes straight from a flip-flop
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            analog_on    <= 1'b0;
            ref_external <= 1'b0;
            channel      <= 3'h0;
            sample_hold  <= 1'b0;
            conv_tick    <= 1'b0;
            irq          <= 1'b0;
        end
        else
        begin
            analog_on    <= converter_enable || wr_en;          // [RULE5]
            ref_external <= reference_select;                   // [RULE2]
            channel      <= channel_select;                     // [RULE3]
            // Hold only during conversion; never a discharge pulse
            sample_hold  <= (in_conv || go) && !finish
                            && !sw_abort && !off_abort;         // [RULE11]
            conv_tick    <= in_conv && tick;
            // Finish folded in so irq rises with the flag
            irq          <= (conversion_done_flag || finish) && done_mask;
        end
    end
endmodule : acr_top

`default_nettype wire

/* acr_top_sva.sv */
/* Port checker for acr_top: register port, front end, irq.
   Assumes one clock, sys_clk, and active-low async reset rstn. */
`timescale 1ns/1ns
`default_nettype none
module acr_top_chk (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rstn,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // Front end and interrupt
    input wire logic       ref_external,
    input wire logic [2:0] channel,
    input wire logic       sample_hold,
    input wire logic       conv_tick,
    input wire logic       irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Decoded writes
    wire wr0 = reg_write && reg_addr == acr_pkg::ADDR_CTRL0;
    wire wrq = reg_write && reg_addr[2];
    logic       en_q;   // Enable bit as last written
    logic [3:0] ticks;  // Ticks seen in this conversion
    logic [9:0] quiet;  // Cycles since a write in flight, saturating
    // Track enable, count ticks per conversion
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            en_q <= 1'b0;
        else if (wr0)
            en_q <= reg_wdata[acr_pkg::BIT_ENABLE];
    end
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ticks <= 4'h0;
        else if (conv_tick)
            ticks <= ticks + 4'h1;
        else if (!sample_hold)
            ticks <= 4'h0;
    end
    // Hold off the start check through any abort delay
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            quiet <= 10'h3ff;
        else if (wr0 && sample_hold)
            quiet <= 10'h000;
        else if (quiet != 10'h3ff)
            quiet <= quiet + 10'h001;
    end
    // Start write with converter on and idle
    sequence s_go;
        wr0 && reg_wdata[acr_pkg::BIT_START] && en_q && !sample_hold
            && quiet == 10'h3ff;
    endsequence
    property p_ref;
        $changed(ref_external) |-> $past(wr0) || $past(wr0, 2);
    endproperty
    a_ref: assert property (p_ref) else $error("ref moved");
    property p_chan;
        $changed(channel) |-> $past(wr0) || $past(wr0, 2);
    endproperty
    a_chan: assert property (p_chan) else $error("chan moved");
    property p_go;
        s_go |-> ##[1:2] sample_hold;
    endproperty
    a_go: assert property (p_go) else $error("no start");
    property p_dis;
        $rose(sample_hold) |-> $past(en_q);
    endproperty
    a_dis: assert property (p_dis) else $error("start off");
    property p_tick;
        ticks <= acr_pkg::CONV_PERIODS;
    endproperty
    a_tick: assert property (p_tick) else $error("ticks");
    property p_irqf;
        $fell(irq) |-> $past(wrq) || $past(wrq, 2);
    endproperty
    a_irqf: assert property (p_irqf) else $error("irq drop");
    property p_irqr;
        $rose(irq) |-> $past(sample_hold, 2) || $past(sample_hold, 3)
            || $past(wrq) || $past(wrq, 2);
    endproperty
    a_irqr: assert property (p_irqr) else $error("irq rise");
    property p_rd;
        !$past(reg_read) |-> reg_rdata == 8'h00;
    endproperty
    a_rd: assert property (p_rd) else $error("rdata idle");
endmodule : acr_top_chk
bind acr_top acr_top_chk u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ref_external(ref_external),
    .channel(channel), .sample_hold(sample_hold),
    .conv_tick(conv_tick), .irq(irq));
`default_nettype wire

/* acr_top_bench.sv */
/* Self-checking bench for acr_top over the register port.
   Assumes the front end is a constant comparator level. */
`timescale 1ns/1ns
`default_nettype none
module acr_top_bench;
    logic       sys_clk, rstn, reg_write, reg_read, cmp_in;
    logic [2:0] reg_addr, channel;
    logic [7:0] reg_wdata, reg_rdata;
    logic       analog_on, ref_external, sample_hold, conv_tick, irq;
    int         mismatches, n_checks, cycles, n, t;
    // Clock codes and their expected dividers
    logic [2:0] codes [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h7};
    int         divs  [7] = '{2, 4, 8, 16, 32, 64, acr_pkg::RC_DIV};
    acr_top dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .cmp_in(cmp_in), .analog_on(analog_on),
        .ref_external(ref_external), .channel(channel),
        .sample_hold(sample_hold), .conv_tick(conv_tick), .irq(irq));
    // Free-running clock
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Verdict and end of run
    task automatic report_and_stop;
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    // Hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One-cycle write strobe, then a gap cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    // Read, compare masked data in the following cycle
    task automatic rd(input logic [2:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata & m, e);
        @(posedge sys_clk);
    endtask : rd
    // Enable, acquire, start, measure busy length
    task automatic run(input logic [7:0] v, input int dv);
        wr(acr_pkg::ADDR_CTRL0, v);
        repeat (20) @(posedge sys_clk);
        wr(acr_pkg::ADDR_CTRL0, v | 8'h02);
        n = 0;
        t = 0;
        @(negedge sys_clk);
        while (sample_hold === 1'b1 && n < 4000)
        begin
            @(negedge sys_clk);
            n++;
            t += int'(conv_tick);
        end
        chk({7'h0, n == 11 * dv - 1}, 8'h01);
        chk(8'(t), 8'h0b);
        @(posedge sys_clk);
    endtask : run
    initial
    begin
        rstn      = 1'b0;
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_addr  = 3'h0;
        reg_wdata = 8'h00;
        cmp_in    = 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        // Reset values, unmapped index, read-as-zero bits
        rd(acr_pkg::ADDR_CTRL0, 8'hff, acr_pkg::CTRL0_RESET);
        rd(acr_pkg::ADDR_CTRL1, 8'hff, 8'h00);
        rd(3'h7, 8'hff, 8'h00);
        wr(acr_pkg::ADDR_CTRL0, 8'hff);
        rd(acr_pkg::ADDR_CTRL0, 8'hff, 8'hdd);
        chk({6'h0, ref_external, analog_on}, 8'h03);
        chk({7'h0, sample_hold}, 8'h00);
        wr(acr_pkg::ADDR_CTRL1, 8'hff);
        rd(acr_pkg::ADDR_CTRL1, 8'hff, 8'h70);
        // Every channel code, converter off, supply reference
        for (int c = 0; c < 8; c++)
        begin
            wr(acr_pkg::ADDR_CTRL0, 8'(c << 2));
            @(negedge sys_clk);
            chk({5'h0, channel}, 8'(c));
            chk({6'h0, ref_external, analog_on}, 8'h00);
            @(posedge sys_clk);
        end
        // Every clock code except 3, right justified, comparator high
        cmp_in <= 1'b1;
        wr(acr_pkg::ADDR_IRQ_MASK, 8'h01);
        for (int i = 0; i < 7; i++)
        begin
            wr(acr_pkg::ADDR_CTRL1, {1'b0, codes[i], 4'h0});
            run(8'h81, divs[i]);
        end
        rd(acr_pkg::ADDR_RES_HIGH, 8'hff, 8'h03);
        rd(acr_pkg::ADDR_RES_LOW, 8'hff, 8'hff);
        rd(acr_pkg::ADDR_CTRL0, 8'h02, 8'h00);
        chk({7'h0, irq}, 8'h01);
        rd(acr_pkg::ADDR_IRQ_STAT, 8'h01, 8'h01);
        wr(acr_pkg::ADDR_IRQ_STAT, 8'h01);
        rd(acr_pkg::ADDR_IRQ_STAT, 8'h01, 8'h00);
        chk({7'h0, irq}, 8'h00);
        // Masked: flag still sets; left justified
        wr(acr_pkg::ADDR_IRQ_MASK, 8'h00);
        wr(acr_pkg::ADDR_CTRL1, 8'h00);
        run(8'h01, 2);
        rd(acr_pkg::ADDR_IRQ_STAT, 8'h01, 8'h01);
        chk({7'h0, irq}, 8'h00);
        rd(acr_pkg::ADDR_RES_HIGH, 8'hff, 8'hff);
        rd(acr_pkg::ADDR_RES_LOW, 8'hc0, 8'hc0);
        // Comparator low, right justified
        cmp_in <= 1'b0;
        run(8'h81, 2);
        rd(acr_pkg::ADDR_RES_HIGH, 8'h03, 8'h00);
        rd(acr_pkg::ADDR_RES_LOW, 8'hff, 8'h00);
        // Abort mid-conversion keeps the old result
        cmp_in <= 1'b1;
        wr(acr_pkg::ADDR_IRQ_STAT, 8'h01);
        wr(acr_pkg::ADDR_CTRL0, 8'h83);
        repeat (5) @(posedge sys_clk);
        wr(acr_pkg::ADDR_CTRL0, 8'h81);
        wr(acr_pkg::ADDR_CTRL0, 8'h83);
        rd(acr_pkg::ADDR_CTRL0, 8'h02, 8'h00);
        chk({7'h0, sample_hold}, 8'h00);
        rd(acr_pkg::ADDR_RES_HIGH, 8'h03, 8'h00);
        rd(acr_pkg::ADDR_RES_LOW, 8'hff, 8'h00);
        rd(acr_pkg::ADDR_IRQ_STAT, 8'h01, 8'h00);
        report_and_stop;
    end
endmodule : acr_top_bench
`default_nettype wire
